// ---- design/root_pointer_context_invalidation.v ----
// Root table base register and context command register of a DMA-remapping unit.
// Operation
// - Root table base sits in bits 63:12, page-aligned 4KB root table.
// - Root base bits at and above host address width are unimplemented, read zero.
// - Programmed base and mode affect nothing until the set-root-pointer command.
// - Mode bits 11:10: 00 legacy, 01 scalable, 10 and 11 reserved.
// - Writing top byte with invalidate bit 63 set starts context-cache invalidation.
// - On completion clear invalidate bit and report actual granularity together.
// - When write-buffer flush is required, flush before invalidating.
// - With non-legacy mode, ignore request and report actual granularity 00.
// - Requested granularity bits 62:61: 01 global, 10 domain, 11 device.
// - Actual granularity bits 60:59: 00 ignored, else performed granularity.
// - Write-only function mask bits 33:32 mask source-id function bits.
// - Write-only source-id bits 31:16 name device target; reads undefined.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "root_ctx_defs.vh"

module root_pointer_context_invalidation
(
  input  wire        sys_clk,
  input  wire        reset_n,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  input  wire [3:0]  reg_byte_en,
  output reg  [31:0] reg_rdata,
  output reg  [63:0] active_root_base,
  output reg  [1:0]  active_mode,
  output reg         buffer_flush,
  output reg         cache_inval,
  output reg  [1:0]  inval_granularity,
  output reg  [15:0] inval_source_id,
  output reg  [1:0]  inval_function_mask
);

  ////////////////////////////////////////////////////////////////////////////
  // States of the invalidation sequencer, one-hot.
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_FLUSH = 4'b0010;
  localparam [3:0] ST_INVAL = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  // Programmed root pointer fields.
  reg [19:0]             root_base_lo;
  reg [`ROOT_HI_W-1:0]   root_base_hi;
  reg [1:0]              root_mode;
  // Context command fields.
  reg                    invalidate_context_cache;
  reg [1:0]              requested_granularity;
  reg [1:0]              actual_granularity;
  reg [15:0]             source_id_field;
  reg [1:0]              function_mask;
  reg                    write_buffer_flush_required;
  // Sequencer.
  reg [3:0]              state;
  reg [3:0]              count;
  reg [3:0]              next_state;

  // Decodes one register offset against the bus address.
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  wire wr_root_lo = reg_write && hit(reg_addr, `OFF_ROOT_LO);
  wire wr_root_hi = reg_write && hit(reg_addr, `OFF_ROOT_HI);
  wire wr_ctx_lo  = reg_write && hit(reg_addr, `OFF_CTX_LO);
  wire wr_ctx_hi  = reg_write && hit(reg_addr, `OFF_CTX_HI);
  wire wr_ctrl    = reg_write && hit(reg_addr, `OFF_CTRL);
  // A start needs the uppermost byte written with the invalidate bit set.
  wire start = wr_ctx_hi && reg_byte_en[3] && reg_wdata[`CTX_HI_ICC]
               && (state == ST_IDLE);
  wire legacy = (active_mode == `MODE_LEGACY);

  ////////////////////////////////////////////////////////////////////////////
  // Root pointer register writes; only bits below host address width are kept.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      root_base_lo <= `ZERO20;
      root_base_hi <= {`ROOT_HI_W{1'b0}};
      root_mode    <= `ZERO2;
    end
    else
    begin
      if (wr_root_lo)
      begin
        root_base_lo <= reg_wdata[`ROOT_LO_BASE_MSB:`ROOT_LO_BASE_LSB];
        root_mode    <= reg_wdata[`ROOT_LO_MODE_MSB:`ROOT_LO_MODE_LSB];
      end
      if (wr_root_hi)
        root_base_hi <= reg_wdata[`ROOT_HI_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active copies load only when software issues the set-root-pointer command.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      active_root_base <= {64'h0000_0000_0000_0000};
      active_mode      <= `ZERO2;
    end
    else if (wr_ctrl && reg_wdata[`CTRL_SET_ROOT_POINTER_CMD])
    begin
      active_root_base <= {{(64-`HOST_ADDRESS_WIDTH){1'b0}}, root_base_hi, root_base_lo,
                           12'h000};
      active_mode      <= root_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Context command fields and the write-buffer flush requirement.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      source_id_field             <= 16'h0000;
      function_mask               <= `ZERO2;
      requested_granularity       <= `ZERO2;
      write_buffer_flush_required <= 1'b0;
    end
    else
    begin
      if (wr_ctx_lo && state == ST_IDLE)
        source_id_field <= reg_wdata[`CTX_LO_SID_MSB:`CTX_LO_SID_LSB];
      if (wr_ctx_hi && state == ST_IDLE)
      begin
        function_mask         <= reg_wdata[`CTX_HI_FM_MSB:`CTX_HI_FM_LSB];
        requested_granularity <= reg_wdata[`CTX_HI_REQ_MSB:`CTX_HI_REQ_LSB];
      end
      if (wr_ctrl)
        write_buffer_flush_required <= reg_wdata[`CTRL_WRITE_BUFFER_FLUSH_REQUIRED];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state of the invalidation sequencer.
  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start)
        begin
          if (!legacy)
            next_state = ST_DONE;
          else if (write_buffer_flush_required)
            next_state = ST_FLUSH;
          else
            next_state = ST_INVAL;
        end
      ST_FLUSH:
        if (count == `CNT_ONE)
          next_state = ST_INVAL;
      ST_INVAL:
        if (count == `CNT_ONE)
          next_state = ST_DONE;
      ST_DONE:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer registers, invalidate bit, outputs to the cache.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state                    <= ST_IDLE;
      count                    <= `CNT_ZERO;
      invalidate_context_cache <= 1'b0;
      actual_granularity       <= `GRAN_NONE;
      buffer_flush             <= 1'b0;
      cache_inval              <= 1'b0;
      inval_granularity        <= `GRAN_NONE;
      inval_source_id          <= 16'h0000;
      inval_function_mask      <= `ZERO2;
    end
    else
    begin
      state        <= next_state;
      buffer_flush <= 1'b0;
      cache_inval  <= 1'b0;
      if (count != `CNT_ZERO)
        count <= count - `CNT_ONE;
      if (start)
        invalidate_context_cache <= 1'b1;
      if (next_state == ST_FLUSH && state == ST_IDLE)
      begin
        buffer_flush <= 1'b1;
        count        <= `FLUSH_CYCLES;
      end
      if (next_state == ST_INVAL && state != ST_INVAL)
      begin
        cache_inval         <= 1'b1;
        count               <= `INVAL_CYCLES;
        inval_granularity   <= start ? reg_wdata[`CTX_HI_REQ_MSB:`CTX_HI_REQ_LSB]
                                     : requested_granularity;
        inval_source_id     <= source_id_field;
        inval_function_mask <= start ? reg_wdata[`CTX_HI_FM_MSB:`CTX_HI_FM_LSB]
                                     : function_mask;
      end
      if (state == ST_DONE)
      begin
        invalidate_context_cache <= 1'b0;
        // Granularity performed equals the one requested; reserved 00 counts as none.
        actual_granularity <= legacy ? requested_granularity : `GRAN_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe; unmapped reads are zero.
  always @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= `ZERO32;
    else if (reg_read)
    begin
      case (reg_addr)
        `OFF_ROOT_LO: reg_rdata <= {root_base_lo, root_mode, 10'h000};
        `OFF_ROOT_HI: reg_rdata <= {{(32-`ROOT_HI_W){1'b0}}, root_base_hi};
        `OFF_CTX_LO:  reg_rdata <= `ZERO32;
        `OFF_CTX_HI:  reg_rdata <= {invalidate_context_cache, requested_granularity,
                                    actual_granularity, 27'h000_0000};
        `OFF_CTRL:    reg_rdata <= {31'h0000_0000, write_buffer_flush_required} << 1;
        `OFF_STATUS:  reg_rdata <= {28'h000_0000, state};
        default:      reg_rdata <= `ZERO32;
      endcase
    end
    else
      reg_rdata <= `ZERO32;
  end

endmodule // root_pointer_context_invalidation
`default_nettype wire

// ---- design/root_ctx_defs.vh ----
// Register offsets, field positions and timing constants for the root pointer and context block.
`ifndef ROOT_CTX_DEFS_VH
`define ROOT_CTX_DEFS_VH

// Register byte offsets; each 64-bit register is two 32-bit words.
`define OFF_ROOT_LO      8'h20
`define OFF_ROOT_HI      8'h24
`define OFF_CTX_LO       8'h28
`define OFF_CTX_HI       8'h2C
`define OFF_CTRL         8'h30
`define OFF_STATUS       8'h34

// Field positions inside the 32-bit words.
`define ROOT_LO_BASE_MSB 31
`define ROOT_LO_BASE_LSB 12
`define ROOT_LO_MODE_MSB 11
`define ROOT_LO_MODE_LSB 10
`define CTX_HI_ICC       31
`define CTX_HI_REQ_MSB   30
`define CTX_HI_REQ_LSB   29
`define CTX_HI_ACT_MSB   28
`define CTX_HI_ACT_LSB   27
`define CTX_HI_FM_MSB    1
`define CTX_HI_FM_LSB    0
`define CTX_LO_SID_MSB   31
`define CTX_LO_SID_LSB   16

// Control register bits.
`define CTRL_SET_ROOT_POINTER_CMD        0
`define CTRL_WRITE_BUFFER_FLUSH_REQUIRED        1

// Encodings.
`define MODE_LEGACY      2'b00
`define GRAN_NONE        2'b00

// Host address width and reset values.
`define HOST_ADDRESS_WIDTH              48
`define ROOT_HI_W        16
`define ZERO32           32'h0000_0000
`define ZERO2            2'b00
`define ZERO20           20'h0_0000

// Cycle counts for the flush and invalidation work.
`define FLUSH_CYCLES     4'h4
`define INVAL_CYCLES     4'h8
`define CNT_ONE          4'h1
`define CNT_ZERO         4'h0

`endif

// ---- verif/rpci_checker_properties.sv ----
// Port assertions for the root pointer and context command block.
`timescale 1ns/1ps
`default_nettype none
module rpci_checker
(
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [3:0]  reg_byte_en,
  input wire logic [31:0] reg_rdata,
  input wire logic [63:0] active_root_base,
  input wire logic [1:0]  active_mode,
  input wire logic        buffer_flush,
  input wire logic        cache_inval
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic set_root_pointer_cmd_q;
  logic start_q;
  logic rd_q;
  // Remember last cycle's strobes so outputs can be tied to their cause.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      set_root_pointer_cmd_q <= 1'b0;
      start_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else
    begin
      set_root_pointer_cmd_q <= reg_write && reg_addr == 8'h30 && reg_wdata[0];
      start_q <= reg_write && reg_addr == 8'h2C && reg_byte_en[3] && reg_wdata[31];
      rd_q <= reg_read;
    end
  end
  a_root_hold: assert property (!set_root_pointer_cmd_q |-> $stable(active_root_base))
    else $error("active base moved without set root pointer");
  a_mode_hold: assert property (!set_root_pointer_cmd_q |-> $stable(active_mode))
    else $error("active mode moved without set root pointer");
  a_base_align: assert property (active_root_base[11:0] == 12'h000 && active_root_base[63:48] == 16'h0000)
    else $error("active base has bits outside the implemented range");
  a_flush_lead: assert property (buffer_flush |-> ##4 cache_inval)
    else $error("flush not followed by invalidation");
  a_flush_cause: assert property (buffer_flush |-> start_q)
    else $error("flush without a start write");
  a_inval_cause: assert property (cache_inval |-> start_q || $past(buffer_flush, 4))
    else $error("invalidation without a start write");
  a_inval_legacy: assert property (cache_inval |-> active_mode == 2'b00)
    else $error("invalidation issued in non-legacy mode");
  a_inval_single: assert property (cache_inval |=> !cache_inval)
    else $error("invalidation pulse longer than one cycle");
  a_rdata_idle: assert property (!rd_q |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside the read answer cycle");
endmodule // rpci_checker
bind root_pointer_context_invalidation rpci_checker u_chk
(
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_byte_en(reg_byte_en),
  .reg_rdata(reg_rdata), .active_root_base(active_root_base), .active_mode(active_mode),
  .buffer_flush(buffer_flush), .cache_inval(cache_inval)
);
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the root pointer and context command block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [3:0]  reg_byte_en = 4'hF;
  logic [31:0] reg_rdata, rd_val;
  logic [63:0] active_root_base;
  logic [1:0]  active_mode, inval_granularity, inval_function_mask, got_g, got_fm;
  logic        buffer_flush, cache_inval;
  logic [15:0] inval_source_id, got_sid;
  int          n_fail = 0, samples_checked = 0, n_inv = 0, n_fl = 0;
  root_pointer_context_invalidation u_dut
  (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_byte_en(reg_byte_en),
    .reg_rdata(reg_rdata), .active_root_base(active_root_base),
    .active_mode(active_mode), .buffer_flush(buffer_flush), .cache_inval(cache_inval),
    .inval_granularity(inval_granularity), .inval_source_id(inval_source_id),
    .inval_function_mask(inval_function_mask)
  );
  always #4 sys_clk = ~sys_clk;
  // Count issued pulses and keep what came with the last invalidation.
  always @(posedge sys_clk)
  begin
    if (cache_inval === 1'b1)
    begin
      n_inv++;
      got_g = inval_granularity;
      got_sid = inval_source_id;
      got_fm = inval_function_mask;
    end
    if (buffer_flush === 1'b1)
      n_fl++;
  end
  task automatic chk(input logic [63:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // Start an invalidation, try a refused restart while busy, poll for completion.
  task automatic inv(input logic [1:0] g, act, input int fl);
    int i0, f0;
    i0 = n_inv;
    f0 = n_fl;
    wr(8'h28, 32'h0123_0000);
    // Start with the granularity in the same write, then a rewrite in the very
    // next cycle with the strobe held, while every path is still busy.
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= 8'h2C;
    reg_wdata <= {1'b1, g, 27'h0, 2'h2};
    @(posedge sys_clk);
    reg_wdata <= {1'b1, ~g, 29'h0};
    @(posedge sys_clk);
    reg_write <= 1'b0;
    rd_val = 32'h8000_0000;
    for (int k = 0; k < 20 && rd_val[31] !== 1'b0; k++)
      rd(8'h2C);
    chk(rd_val, {1'b0, g, act, 27'h0});
    chk(n_inv - i0, act != 2'b00);
    chk(n_fl - f0, fl);
    if (act != 2'b00)
    begin
      chk(got_g, g);
      chk(got_sid, 16'h0123);
      chk(got_fm, 2'h2);
    end
  endtask
  // A command write that leaves out the uppermost byte must not start anything.
  task automatic no_start;
    int i0;
    i0 = n_inv;
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= 8'h2C;
    reg_wdata <= 32'hA000_0000;
    reg_byte_en <= 4'h7;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_byte_en <= 4'hF;
    rd(8'h2C);
    chk(rd_val[31], 1'b0);
    chk(n_inv - i0, 0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_fail++;
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h20);
    chk(rd_val, 0);
    rd(8'h40);
    chk(rd_val, 0);
    wr(8'h20, 32'hABCD_E400);
    wr(8'h24, 32'hFFFF_1234);
    rd(8'h24);
    chk(rd_val, 32'h0000_1234);
    chk(active_root_base, 0);
    wr(8'h30, 32'h0000_0001);
    @(posedge sys_clk);
    #1;
    chk(active_root_base, 64'h0000_1234_ABCD_E000);
    chk(active_mode, 2'b01);
    inv(2'b01, 2'b00, 0);
    wr(8'h20, 32'h0000_5000);
    wr(8'h30, 32'h0000_0001);
    rd(8'h28);
    chk(rd_val, 0);
    for (int g = 1; g < 4; g++)
      inv(g[1:0], g[1:0], 0);
    no_start;
    wr(8'h30, 32'h0000_0002);
    inv(2'b10, 2'b10, 1);
    // The IOTLB invalidation that follows each completion lies outside this block.
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
